// file: common/dpram_host_pkg.sv
// Constants for the host-side controller of one port of an async dual-port RAM
// Function
// RULE1: Hold write_not_read high during every read
// RULE2: Address changes only while write_not_read high
// RULE3: Address valid before chip select falls (code drives address and chip select on the same clock edge)
// RULE4: Write only during select and lane overlap
// RULE5: Late select after write keeps outputs floating
// RULE6: Never select array and flags together
// RULE7: Array write stores only selected byte lanes
// RULE8: Array read drives only selected lanes
// RULE9: Flag read returns flag on all lines
// RULE10: Free flag reads one; taker reads zero
// RULE11: One from non-owner changes nothing
// RULE12: Owner release passes token to requester
// RULE13: Owner release without request frees flag
// RULE14: All flags free at start
// RULE15: Simultaneous requests grant exactly one port
// RULE16: Left write of top address sets right flag
// RULE17: Right read of top address clears flag
// RULE18: Right write of next address sets left
// RULE19: Left read of next address clears flag
// RULE20: Deep variant uses FFFF and FFFE
// RULE21: Mailbox access ignored while port busy
// RULE22: Same address race busies exactly one port
// RULE23: Busy low on loser until mismatch
// RULE24: Role pin selects busy output or input
package dpram_host_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 16;
    localparam int LANE_W = 8;
    localparam logic [ADDR_W-1:0] MBOX_RIGHT_ADDR = 15'h7FFF;
    localparam logic [ADDR_W-1:0] MBOX_LEFT_ADDR = 15'h7FFE;
    // Strobe phase lengths, in ns, and derived cycles at 200 MHz
    localparam int CLK_PERIOD_PS = 5000;
    localparam int SETUP_NS = 5;
    localparam int STROBE_NS = 25;
    localparam int HOLD_NS = 5;
    localparam int SETUP_CYC = (SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STROBE_CYC = (STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HOLD_CYC = (HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 4;
    typedef enum logic [1:0] {
        OP_ARRAY_READ,
        OP_ARRAY_WRITE,
        OP_FLAG_READ,
        OP_FLAG_WRITE
    } op_t;
endpackage

// file: common/strobe_if.sv
// Handshake between the sequencer and the phase timer
`timescale 1ns/100ps
`default_nettype none
interface strobe_if;
    logic start;
    logic [3:0] len;
    logic done;
    modport seq (output start, output len, input done);
    modport tmr (input start, input len, output done);
endinterface
`default_nettype wire

// file: core/phase_timer.sv
// Down counter that times one strobe phase
`timescale 1ns/100ps
`default_nettype none
module phase_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Sequencer side
    strobe_if.tmr s
);
    logic [3:0] cnt_q;
    logic run_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= 4'h0;
            run_q <= 1'b0;
        end else if (s.start) begin
            cnt_q <= s.len;
            run_q <= 1'b1;
        end else if (run_q) begin
            if (cnt_q <= 4'h1) begin
                run_q <= 1'b0;
            end
            cnt_q <= cnt_q - 4'h1;
        end
    end

    assign s.done = run_q && (cnt_q <= 4'h1);
endmodule
`default_nettype wire

// file: core/dpram_port_host.sv
// Host controller that runs array, flag and mailbox cycles on one RAM port
`timescale 1ns/100ps
`default_nettype none
module dpram_port_host
    import dpram_host_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // User request
    input wire logic req_valid,
    input wire logic [1:0] req_op,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    input wire logic [1:0] req_lanes,
    output logic req_ready,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    output logic rsp_busy_hit,
    output logic mbox_pending,
    // Device pins
    output logic [ADDR_W-1:0] addr,
    output logic chip_select_n,
    output logic flag_select_n,
    output logic write_not_read,
    output logic output_drive_enable_n,
    output logic upper_lane_select_n,
    output logic lower_lane_select_n,
    input wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0] data_out,
    output logic [DATA_W-1:0] data_oe_n,
    input wire logic busy_n_pin,
    input wire logic mailbox_flag_n_pin
);
    typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_DONE} state_t;
    state_t state_q;
    op_t op_q;
    strobe_if tif ();
    logic start_q;
    logic [3:0] len_q;
    logic [2:0] busy_sync_q;
    logic [2:0] mbox_sync_q;
    logic busy_hit_q;

    assign tif.start = start_q;
    assign tif.len = len_q;

    phase_timer u_timer (
        .clk(clk),
        .resetn(resetn),
        .s(tif)
    );

    function automatic logic is_write(input op_t o);
        return (o == OP_ARRAY_WRITE) || (o == OP_FLAG_WRITE);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: a change counts once stages two and three agree
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy_sync_q <= 3'h7;
            mbox_sync_q <= 3'h7;
        end else begin
            busy_sync_q <= {busy_sync_q[1:0], busy_n_pin}; // RULE24
            mbox_sync_q <= {mbox_sync_q[1:0], mailbox_flag_n_pin};
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mbox_pending <= 1'b0;
        end else if (mbox_sync_q[2] == mbox_sync_q[1]) begin
            mbox_pending <= !mbox_sync_q[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Cycle sequencer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
            op_q <= OP_ARRAY_READ;
            start_q <= 1'b0;
            len_q <= 4'h1;
        end else begin
            start_q <= 1'b0;
            unique case (state_q)
                ST_IDLE: begin
                    if (req_valid) begin
                        op_q <= op_t'(req_op);
                        state_q <= ST_SETUP;
                        start_q <= 1'b1;
                        len_q <= CNT_W'(SETUP_CYC);
                    end
                end
                ST_SETUP: begin
                    if (tif.done) begin
                        state_q <= ST_STROBE;
                        start_q <= 1'b1;
                        len_q <= CNT_W'(STROBE_CYC);
                    end
                end
                ST_STROBE: begin
                    if (tif.done) begin
                        state_q <= ST_HOLD;
                        start_q <= 1'b1;
                        len_q <= CNT_W'(HOLD_CYC);
                    end
                end
                ST_HOLD: begin
                    if (tif.done) begin
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address, data and lanes are latched at acceptance and held throughout,
    // so the address only moves in idle with write_not_read high
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            addr <= '0;
            data_out <= '0;
            upper_lane_select_n <= 1'b1;
            lower_lane_select_n <= 1'b1;
        end else if (state_q == ST_IDLE && req_valid) begin
            addr <= req_addr; // RULE2 RULE3
            data_out <= req_wdata;
            // Flag accesses keep both lanes high so select never collides
            if (req_op[1]) begin
                upper_lane_select_n <= 1'b1; // RULE6
                lower_lane_select_n <= 1'b1;
            end else begin
                upper_lane_select_n <= !req_lanes[1]; // RULE7 RULE8
                lower_lane_select_n <= !req_lanes[0];
            end
        end else if (state_q == ST_DONE) begin
            upper_lane_select_n <= 1'b1;
            lower_lane_select_n <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Strobes: selects asserted through setup, strobe and hold; write_not_read
    // low only in the strobe phase so the write ends before select rises
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            chip_select_n <= 1'b1;
            flag_select_n <= 1'b1;
            write_not_read <= 1'b1;
            output_drive_enable_n <= 1'b1;
            data_oe_n <= '1;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (req_valid) begin
                        chip_select_n <= req_op[1]; // RULE6
                        flag_select_n <= !req_op[1];
                        output_drive_enable_n <= is_write(op_t'(req_op));
                    end
                end
                ST_SETUP: begin
                    if (tif.done && is_write(op_q)) begin
                        write_not_read <= 1'b0; // RULE4 RULE1
                        data_oe_n <= '0;
                    end
                end
                ST_STROBE: begin
                    if (tif.done) begin
                        write_not_read <= 1'b1;
                    end
                end
                ST_HOLD: begin
                    if (tif.done) begin
                        chip_select_n <= 1'b1;
                        flag_select_n <= 1'b1;
                        output_drive_enable_n <= 1'b1;
                        data_oe_n <= '1;
                    end
                end
                ST_DONE: begin
                    data_oe_n <= '1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read capture near strobe end; busy seen during the strobe is reported,
    // since the device drops mailbox accesses on a busy port
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rsp_rdata <= '0;
            rsp_valid <= 1'b0;
            rsp_busy_hit <= 1'b0;
            busy_hit_q <= 1'b0;
            req_ready <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            req_ready <= (state_q == ST_IDLE) && !req_valid;
            if (state_q == ST_IDLE) begin
                busy_hit_q <= 1'b0;
            end else if (state_q == ST_STROBE && busy_sync_q[2] == busy_sync_q[1]
                         && !busy_sync_q[2]) begin
                busy_hit_q <= 1'b1; // RULE21 RULE23
            end
            if (state_q == ST_STROBE && tif.done && !is_write(op_q)) begin
                // Flag reads return the flag on every line; bit 0 is enough
                rsp_rdata <= (op_q == OP_FLAG_READ) ? {{(DATA_W-1){1'b0}}, data_in[0]}
                                                    : data_in; // RULE9 RULE10
            end
            if (state_q == ST_DONE) begin
                rsp_valid <= 1'b1;
                rsp_busy_hit <= busy_hit_q;
            end
        end
    end
endmodule
`default_nettype wire

// file: test/dpram_port_host_assertions.sv
// Pin protocol checks for the port host
`timescale 1ns/100ps
`default_nettype none
module dpram_port_host_assertions (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Device pins
    input wire logic [14:0] addr,
    input wire logic chip_select_n,
    input wire logic flag_select_n,
    input wire logic write_not_read,
    input wire logic upper_lane_select_n,
    input wire logic lower_lane_select_n,
    input wire logic [15:0] data_oe_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_read_hold;
        !(chip_select_n && flag_select_n) && data_oe_n == 16'hFFFF |-> write_not_read;
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("write during read");
    property p_addr_chg;
        $changed(addr) |-> write_not_read && $past(write_not_read);
    endproperty
    a_addr_chg: assert property (p_addr_chg) else $error("address moved in write");
    property p_addr_cs;
        !chip_select_n && $past(!chip_select_n) |-> $stable(addr);
    endproperty
    a_addr_cs: assert property (p_addr_cs) else $error("address moved while selected");
    property p_excl;
        chip_select_n || flag_select_n;
    endproperty
    a_excl: assert property (p_excl) else $error("array and flags selected");
    property p_wr_sel;
        !write_not_read |-> chip_select_n != flag_select_n;
    endproperty
    a_wr_sel: assert property (p_wr_sel) else $error("write without select");
    property p_wr_len;
        $fell(write_not_read) |-> (!write_not_read) [*6] ##1 write_not_read;
    endproperty
    a_wr_len: assert property (p_wr_len) else $error("write pulse length");
endmodule
bind dpram_port_host dpram_port_host_assertions dpram_port_host_assertions_i (
    .clk(clk), .resetn(resetn), .addr(addr), .chip_select_n(chip_select_n),
    .flag_select_n(flag_select_n), .write_not_read(write_not_read),
    .upper_lane_select_n(upper_lane_select_n), .lower_lane_select_n(lower_lane_select_n),
    .data_oe_n(data_oe_n));
`default_nettype wire

// file: test/ram_device_model.sv
// Behavioural RAM with flags and mailbox; the host sits on the left port
`timescale 1ns/100ps
`default_nettype none
module ram_device_model (
    // Left port pins
    input wire logic clk,
    input wire logic [14:0] addr,
    input wire logic chip_select_n,
    input wire logic flag_select_n,
    input wire logic write_not_read,
    input wire logic output_drive_enable_n,
    input wire logic upper_lane_select_n,
    input wire logic lower_lane_select_n,
    input wire logic [15:0] data_out,
    input wire logic [15:0] data_oe_n,
    output logic [15:0] data_in,
    output logic busy_n_pin,
    output logic mailbox_flag_n_pin,
    // Right port, abstracted
    input wire logic r_sel,
    input wire logic [14:0] r_addr,
    input wire logic r_sem_we,
    input wire logic r_sem_d,
    input wire logic [2:0] r_sem_i,
    input wire logic r_mbox_set,
    input wire logic r_mbox_clr,
    output logic r_int,
    output logic [7:0] r_sem_q
);
    logic [15:0] mem [0:32767];
    logic [7:0] lt = 8'h00, rt = 8'h00, lq = 8'h00, rq = 8'h00;
    logic l_int = 1'b0, ri = 1'b0, wnr_q = 1'b1;
    logic [15:0] wd, lm, junk = 16'hA5C3;
    logic [1:0] ln;
    wire logic arr = !chip_select_n && flag_select_n;
    wire logic fl = chip_select_n && !flag_select_n;
    wire logic [2:0] i = addr[2:0];
    wire logic l_take = write_not_read && !wnr_q && fl && !wd[0] && !rt[i];
    // Arbiter role: busy is an output, and the left port always loses a race
    assign busy_n_pin = !(r_sel && r_addr == addr && !chip_select_n);
    assign mailbox_flag_n_pin = !l_int;
    assign r_int = ri;
    assign r_sem_q = ~rt;
    assign lm = {{8{!upper_lane_select_n}}, {8{!lower_lane_select_n}}};
    // Undriven lines wander so a stale value never reads as good data
    always_comb begin
        for (int b = 0; b < 16; b++) begin
            if (write_not_read && !output_drive_enable_n && (fl || (arr && lm[b])))
                data_in[b] = fl ? !lt[i] : mem[addr][b];
            else
                data_in[b] = data_oe_n[b] ? junk[b] : data_out[b];
        end
    end
    always @(posedge clk) begin
        junk <= {junk[14:0], junk[15] ^ junk[4]};
        wnr_q <= write_not_read;
        if (!write_not_read) begin
            wd <= data_in;
            ln <= {!upper_lane_select_n, !lower_lane_select_n};
        end
        if (write_not_read && !wnr_q && arr) begin
            mem[addr] <= (wd & {{8{ln[1]}}, {8{ln[0]}}}) | (mem[addr] & ~{{8{ln[1]}}, {8{ln[0]}}});
            if (&addr && busy_n_pin)
                ri <= 1'b1;
        end
        if (write_not_read && !wnr_q && fl) begin
            if (!wd[0] && !rt[i])
                lt[i] <= 1'b1;
            else if (!wd[0])
                lq[i] <= 1'b1;
            else if (lt[i]) begin
                lt[i] <= 1'b0;
                rt[i] <= rq[i];
                rq[i] <= 1'b0;
            end
        end
        // A left take in the same cycle wins, so the right side only queues
        if (r_sem_we && !r_sem_d && !lt[r_sem_i] && !(l_take && i == r_sem_i))
            rt[r_sem_i] <= 1'b1;
        else if (r_sem_we && !r_sem_d)
            rq[r_sem_i] <= 1'b1;
        else if (r_sem_we && rt[r_sem_i]) begin
            rt[r_sem_i] <= 1'b0;
            lt[r_sem_i] <= lq[r_sem_i];
            lq[r_sem_i] <= 1'b0;
        end
        if (arr && write_not_read && !output_drive_enable_n && &addr[14:1] && !addr[0]
            && busy_n_pin)
            l_int <= 1'b0;
        if (r_mbox_set)
            l_int <= 1'b1;
        if (r_mbox_clr)
            ri <= 1'b0;
    end
endmodule
`default_nettype wire

// file: test/dual_port_ram_mailbox_semaphores_tb.sv
// Random and directed run of the port host against the device model
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; $display("Error %0t: got %h exp %h", $time, g, e); end end
module dual_port_ram_mailbox_semaphores_tb;
    import dpram_host_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, req_valid = 1'b0;
    logic [1:0] req_op = 2'h0, req_lanes = 2'h0;
    logic [ADDR_W-1:0] req_addr = '0, addr, r_addr = '0, a;
    logic [DATA_W-1:0] req_wdata = '0, rsp_rdata, data_in, data_out, data_oe_n, d, e, q;
    logic req_ready, rsp_valid, rsp_busy_hit, mbox_pending, busy_n_pin, mailbox_flag_n_pin;
    logic chip_select_n, flag_select_n, write_not_read, output_drive_enable_n;
    logic upper_lane_select_n, lower_lane_select_n, r_int;
    logic r_sel = 1'b0, r_sem_we = 1'b0, r_sem_d = 1'b0, r_mbox_set = 1'b0, r_mbox_clr = 1'b0;
    logic [2:0] r_sem_i = 3'h0;
    logic [7:0] r_sem_q;
    logic [1:0] l;
    int failures = 0, n_tests = 0, cyc = 0, seed = 32'h7af1;
    dpram_port_host dpram_port_host_i (.*);
    ram_device_model ram_device_model_i (.*);
    always #2.5 clk = ~clk;
    task automatic end_sim();
        if (failures == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Generous ceiling: 5000 cycles, about 450 of the 11-cycle accesses
    always @(posedge clk) begin
        cyc++;
        if (cyc > 5000) begin
            failures++;
            end_sim();
        end
    end
    task automatic op(input logic [1:0] o, input logic [14:0] ad, input logic [15:0] wd,
            input logic [1:0] ln);
        @(posedge clk);
        #1;
        req_op = o;
        req_addr = ad;
        req_wdata = wd;
        req_lanes = ln;
        req_valid = 1'b1;
        do begin
            @(posedge clk);
            #1;
        end while (rsp_valid !== 1'b1);
        req_valid = 1'b0;
        q = rsp_rdata;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(posedge clk);
        #1;
        s = 1'b0;
    endtask
    task automatic fchk(input logic [1:0] ex);
        op(2'd2, {12'h0, r_sem_i}, 16'h0, 2'b00);
        `CHK(({q[0], r_sem_q[r_sem_i]}), ex)
    endtask
    function automatic logic [15:0] merge(input logic [15:0] o, n, input logic [1:0] ln);
        logic [15:0] m;
        m = {{8{ln[1]}}, {8{ln[0]}}};
        return (n & m) | (o & ~m);
    endfunction
    initial begin
        repeat (12) @(posedge clk);
        #1 resetn = 1'b1;
        repeat (8) begin
            a = $random(seed) & 15'h3FFF;
            d = $random(seed);
            e = $random(seed);
            l = $random(seed);
            op(2'd1, a, d, 2'b11);
            op(2'd1, a, e, l);
            e = merge(d, e, l);
            op(2'd0, a, 16'h0, 2'b11);
            `CHK(q, e)
            op(2'd0, a, 16'h0, 2'b01);
            `CHK(q[7:0], e[7:0])
        end
        r_sem_i = $random(seed);
        fchk(2'b11);
        op(2'd3, {12'h0, r_sem_i}, 16'h0, 2'b00);
        fchk(2'b01);
        pulse(r_sem_we);
        fchk(2'b01);
        op(2'd3, {12'h0, r_sem_i}, 16'h1, 2'b00);
        fchk(2'b10);
        r_sem_d = 1'b1;
        pulse(r_sem_we);
        fchk(2'b11);
        r_sem_d = 1'b0;
        fork
            op(2'd3, {12'h0, r_sem_i}, 16'h0, 2'b00);
            begin
                // Right request lands on the edge that ends the left write
                repeat (10) @(posedge clk);
                #1 pulse(r_sem_we);
            end
        join
        op(2'd2, {12'h0, r_sem_i}, 16'h0, 2'b00);
        `CHK(q[0] ^ r_sem_q[r_sem_i], 1'b1)
        op(2'd1, 15'h7FFF, 16'h1234, 2'b11);
        `CHK(r_int, 1'b1)
        pulse(r_mbox_set);
        repeat (5) @(posedge clk);
        #1 `CHK(({mbox_pending, req_ready}), 2'b11)
        op(2'd0, 15'h7FFE, 16'h0, 2'b11);
        repeat (5) @(posedge clk);
        #1 `CHK(mbox_pending, 1'b0)
        pulse(r_mbox_clr);
        r_sel = 1'b1;
        r_addr = 15'h7FFF;
        op(2'd1, 15'h7FFF, 16'h0, 2'b11);
        `CHK(({rsp_busy_hit, r_int}), 2'b10)
        r_sel = 1'b0;
        op(2'd1, 15'h7FFF, 16'h0, 2'b11);
        `CHK(({rsp_busy_hit, r_int}), 2'b01)
        end_sim();
    end
endmodule
`default_nettype wire
